// ==== cursor_pkg.sv ====
// constants shared by the cursor block
package cursor_pkg;
  localparam logic [3:0] write_addr_off    = 4'h0;
  localparam logic [3:0] read_addr_off     = 4'h3;
  localparam logic [3:0] ram_data_off      = 4'hb;
  localparam logic [7:0] ctrl_index        = 8'h06;
  localparam int         style_lo_pos      = 0;
  localparam int         style_hi_pos      = 1;
  localparam int         addr_bit8_pos     = 2;
  localparam int         plane_sel_pos     = 3;
  localparam int         retrace_sel_pos   = 4;
  localparam logic [7:0] ctrl_reset        = 8'h00;
  localparam int         ram_bytes         = 1024;
  localparam int         plane_bytes       = 512;
  localparam int         cursor_size       = 64;
  localparam logic [12:0] retrace_short    = 13'h0800;
  localparam logic [12:0] retrace_long     = 13'h1000;
  localparam logic [1:0] style_off         = 2'h0;
  localparam logic [1:0] style_three       = 2'h1;
  localparam logic [1:0] style_compl       = 2'h2;
  localparam logic [1:0] style_transp      = 2'h3;
  localparam logic [1:0] style_default     = 2'h2;
  localparam int         buf_depth         = 2;
endpackage

// ==== pix_skid_buf.sv ====
// two-entry valid/ready buffer for cursor pixel words
`timescale 1ns/1ps
module pix_skid_buf #(
  parameter int width = 24
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [width-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [width-1:0]      out_data
);
  logic [width-1:0] mem_q [0:1];
  logic [width-1:0] mem_d [0:1];
  logic             wp_q, wp_d, rp_q, rp_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (push) begin
      mem_d[wp_q] = in_data;
    end
    wp_d  = push ? ~wp_q : wp_q;
    rp_d  = pop ? ~rp_q : rp_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    mem_q[0] <= mem_d[0];
    mem_q[1] <= mem_d[1];
    if (reset) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== hw_cursor.sv ====
// hardware cursor: pattern ram, host port, position, retrace detect, pixel mix
// Overview of operation
// - pattern ram is 1024 bytes, 10-bit byte address, reached over 8-bit host bus
// - plane 0 bits in lower 512 bytes, plane 1 bits in upper 512
// - each byte holds eight pixels of one plane, bit seven leftmost
// - address zero is top-left, addresses run in display order
// - address bits 9 and 8 come from control register index 0x06
// - low address from write-address reg 0 for writes, reg 3 for reads
// - data register write stores byte then advances the full address
// - data register read returns byte then advances the full address
// - ram uninitialised, host access allowed any time, also while displaying
// - reset clears the two upper address bits
// - writing either low-address register loads all ten counter bits
// - retrace when 2048 or 4096 clocks between blank rising edges, select bit
// - position is bottom-right cursor pixel from blank end, x right y down
// - x or y position zero shows no cursor
// - position (1,1) shows only pattern pixel (63,63) at top-left
// - default colour-plus-complement, also transparent and three-colour styles; reset loads control 0x00, style 00 off
// - big-endian reverse-wired pixel bus latches as little-endian
// - 4444 format: overlay 15..12, blue 11..8, green 7..4, red 3..0
// - style 00 off, 01 three-colour, 10 complement, 11 transparent
// - complement code outputs one's complement of underlying colour
`timescale 1ns/1ps
module hw_cursor #(
  parameter int pos_width = 12
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  input  wire logic                 ind_wr,
  input  wire logic [7:0]           ind_index,
  input  wire logic [7:0]           ind_wdata,
  output logic [7:0]                ctrl_rdata,
  input  wire logic [pos_width-1:0] pos_x,
  input  wire logic [pos_width-1:0] pos_y,
  input  wire logic                 blank_n,
  input  wire logic                 pix_valid,
  input  wire logic [15:0]          pix_in,
  input  wire logic [23:0]          cursor_color0,
  input  wire logic [23:0]          cursor_color1,
  input  wire logic [23:0]          cursor_color2,
  output logic                      pix_in_ready,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [23:0]               out_rgb,
  output logic [3:0]                out_overlay,
  output logic                      retrace
);
  // pattern memory, left undefined at power-up
  logic [7:0] pat_ram [0:cursor_pkg::ram_bytes-1];

  // control register and host address counter
  logic [7:0] ctrl_q, ctrl_d;
  logic [9:0] haddr_q, haddr_d;
  logic [7:0] rdata_q, rdata_d;
  logic       ram_we;
  logic [7:0] ram_rd_byte;

  function automatic logic [9:0] next_addr(input logic [9:0] a);
    next_addr = a + 10'h001;
  endfunction

  // the two low-address registers share one load path
  function automatic logic is_low_addr(input logic [3:0] a);
    is_low_addr = (a == cursor_pkg::write_addr_off) || (a == cursor_pkg::read_addr_off);
  endfunction

  // 4-bit colour field widened to a full byte
  function automatic logic [7:0] widen(input logic [3:0] n);
    widen = {n, n};
  endfunction

  assign ctrl_rdata = ctrl_q;
  assign ram_we     = reg_wr && (reg_addr == cursor_pkg::ram_data_off);
  assign ram_rd_byte = pat_ram[haddr_q];

  always_comb begin
    ctrl_d  = ctrl_q;
    haddr_d = haddr_q;
    rdata_d = rdata_q;
    if (ind_wr && ind_index == cursor_pkg::ctrl_index) begin
      ctrl_d = ind_wdata;
    end
    if (reg_wr && is_low_addr(reg_addr)) begin
      // all ten bits loaded at once
      haddr_d = {ctrl_d[cursor_pkg::plane_sel_pos], ctrl_d[cursor_pkg::addr_bit8_pos], reg_wdata};
    end else if (ram_we) begin
      haddr_d = next_addr(haddr_q);
    end else if (reg_rd && reg_addr == cursor_pkg::ram_data_off) begin
      rdata_d = ram_rd_byte;
      haddr_d = next_addr(haddr_q);
    end
    if (haddr_d != haddr_q) begin
      // carry out of the low byte shows in the upper control bits
      ctrl_d[cursor_pkg::plane_sel_pos] = haddr_d[9];
      ctrl_d[cursor_pkg::addr_bit8_pos] = haddr_d[8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      pat_ram[haddr_q] <= reg_wdata;
    end
    if (reset) begin
      ctrl_q  <= cursor_pkg::ctrl_reset;
      haddr_q <= 10'h000;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      haddr_q <= haddr_d;
      rdata_q <= rdata_d;
    end
  end

  // low address registers read back, data register returns fetched byte
  always_comb begin
    case (reg_addr)
      cursor_pkg::write_addr_off: reg_rdata = haddr_q[7:0];
      cursor_pkg::read_addr_off:  reg_rdata = haddr_q[7:0];
      cursor_pkg::ram_data_off:   reg_rdata = rdata_q;
      default:                    reg_rdata = 8'h00;
    endcase
  end

  // retrace detect and raster counters
  logic [12:0]          gap_q, gap_d;
  logic                 blank_q, blank_d;
  logic                 retr_q, retr_d;
  logic [pos_width-1:0] sx_q, sx_d, sy_q, sy_d;
  logic [pos_width-1:0] cur_x, cur_y;
  logic                 line_seen_q, line_seen_d;
  logic                 blank_fall, adv;
  logic [12:0]          retrace_gap;

  // blank_q high while blanking; blank_fall is the rising edge of blank_n
  assign blank_fall  = blank_q && blank_n;
  assign retrace_gap = ctrl_q[cursor_pkg::retrace_sel_pos] ? cursor_pkg::retrace_long
                                                          : cursor_pkg::retrace_short;
  assign retrace     = retr_q;

  always_comb begin
    blank_d     = ~blank_n;
    gap_d       = gap_q;
    retr_d      = retr_q;
    cur_x       = sx_q;
    cur_y       = sy_q;
    line_seen_d = line_seen_q;
    // gap measured from one blank_n rise to the next
    if (blank_fall) begin
      gap_d  = 13'h0001;
      retr_d = 1'b0;
    end else if (gap_q != 13'h1fff) begin
      gap_d = gap_q + 13'h0001;
    end
    if (~blank_n && gap_q >= retrace_gap - 13'h0001) begin
      retr_d = 1'b1;
    end
    // first pixel of a line may come in the cycle that blanking ends
    if (blank_fall) begin
      cur_x = '0;
      if (retr_q) begin
        cur_y = '0;
      end else if (line_seen_q) begin
        cur_y = sy_q + 1'b1;
      end
      line_seen_d = 1'b1;
    end
    sx_d = cur_x;
    sy_d = cur_y;
    if (adv && blank_n) begin
      sx_d = cur_x + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blank_q     <= 1'b0;
      gap_q       <= 13'h0000;
      retr_q      <= 1'b0;
      sx_q        <= '0;
      sy_q        <= '0;
      line_seen_q <= 1'b0;
    end else begin
      blank_q     <= blank_d;
      gap_q       <= gap_d;
      retr_q      <= retr_d;
      sx_q        <= sx_d;
      sy_q        <= sy_d;
      line_seen_q <= line_seen_d;
    end
  end

  // window test: pixel (sx,sy) is in cursor if pos-64 <= s < pos
  logic [pos_width:0] dx, dy;
  logic               in_win;
  logic [5:0]         cx, cy;
  logic [9:0]         fetch_a [0:1];
  logic [7:0]         plane_byte [0:1];
  logic [7:0]         p0_byte, p1_byte;
  logic [1:0]         code;

  // current pixel position, already adjusted for a line start
  always_comb begin
    dx     = {1'b0, pos_x} - {1'b0, cur_x} - 1'b1;
    dy     = {1'b0, pos_y} - {1'b0, cur_y} - 1'b1;
    in_win = (pos_x != '0) && (pos_y != '0) &&
             ({1'b0, cur_x} < {1'b0, pos_x}) && ({1'b0, cur_y} < {1'b0, pos_y}) &&
             (dx < (pos_width+1)'(cursor_pkg::cursor_size)) &&
             (dy < (pos_width+1)'(cursor_pkg::cursor_size));
    // pattern column/row counted from the top-left corner, from offsets taken off the bottom-right
    cx = 6'h3f - dx[5:0];
    cy = 6'h3f - dy[5:0];
    // plane bit is the top address bit
    fetch_a[0] = {1'b0, cy, cx[5:3]};
    fetch_a[1] = {1'b1, cy, cx[5:3]};
  end

  // display fetch uses its own read ports, host counter is untouched
  generate
    for (genvar pl = 0; pl < 2; pl++) begin : g_fetch
      assign plane_byte[pl] = pat_ram[fetch_a[pl]];
    end
  endgenerate

  assign p0_byte = plane_byte[0];
  assign p1_byte = plane_byte[1];

  always_comb begin
    code = {p1_byte[3'h7 - cx[2:0]], p0_byte[3'h7 - cx[2:0]]};
  end

  // underlying pixel split in the 4444 format, nibbles widened to 8 bits
  logic [3:0]  u_ovl, u_b, u_g, u_r;
  logic [23:0] under_rgb, mix_rgb;
  logic [1:0]  style;

  assign u_ovl     = pix_in[15:12];
  assign u_b       = pix_in[11:8];
  assign u_g       = pix_in[7:4];
  assign u_r       = pix_in[3:0];
  // bytes ordered as already latched; reverse wiring is external
  assign under_rgb = {widen(u_r), widen(u_g), widen(u_b)};
  assign style     = {ctrl_q[cursor_pkg::style_hi_pos], ctrl_q[cursor_pkg::style_lo_pos]};

  always_comb begin
    mix_rgb = under_rgb;
    if (in_win) begin
      case (style)
        cursor_pkg::style_off: mix_rgb = under_rgb;
        cursor_pkg::style_three: begin
          case (code)
            2'h1:    mix_rgb = cursor_color0;
            2'h2:    mix_rgb = cursor_color1;
            2'h3:    mix_rgb = cursor_color2;
            default: mix_rgb = under_rgb;
          endcase
        end
        cursor_pkg::style_compl: begin
          case (code)
            2'h0:    mix_rgb = cursor_color0;
            2'h1:    mix_rgb = cursor_color1;
            2'h3:    mix_rgb = ~under_rgb;
            default: mix_rgb = under_rgb;
          endcase
        end
        cursor_pkg::style_transp: begin
          case (code)
            2'h2:    mix_rgb = cursor_color0;
            2'h3:    mix_rgb = cursor_color1;
            default: mix_rgb = under_rgb;
          endcase
        end
        default: mix_rgb = under_rgb;
      endcase
    end
  end

  // raster advances only when the buffer takes the pixel
  assign adv = pix_valid && pix_in_ready;

  logic [27:0] buf_out;

  pix_skid_buf #(
    .width(28)
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (pix_valid),
    .in_ready  (pix_in_ready),
    .in_data   ({u_ovl, mix_rgb}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );

  // overlay rides above the colour word through the buffer
  assign out_rgb     = buf_out[23:0];
  assign out_overlay = buf_out[27:24];
endmodule

// ==== hw_cursor_props.sv ====
// port assertions for the hardware cursor block
`timescale 1ns/1ps
module hw_cursor_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ind_wr,
  input wire logic [7:0]  ind_index,
  input wire logic [7:0]  ind_wdata,
  input wire logic [7:0]  ctrl_rdata,
  input wire logic        blank_n,
  input wire logic        pix_in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [23:0] out_rgb,
  input wire logic [3:0]  out_overlay,
  input wire logic        retrace
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic        blank_q;
  logic [12:0] cnt_q;
  // cycles since the last blank rise, saturating
  always_ff @(posedge ref_clk) begin
    blank_q <= blank_n;
    if (reset || (blank_n && !blank_q)) cnt_q <= 13'h0000;
    else if (cnt_q != 13'h1fff) cnt_q <= cnt_q + 13'h0001;
  end
  a_reset_clear: assert property ($fell(reset) |-> ctrl_rdata[3:2] == 2'h0)
    else $error("upper address bits not cleared by reset");
  a_ctrl_write: assert property (ind_wr && ind_index == cursor_pkg::ctrl_index && !reg_wr && !reg_rd
    |=> ctrl_rdata == $past(ind_wdata)) else $error("control write not taken");
  a_ctrl_hold: assert property (!ind_wr && !reg_wr && !reg_rd |=> $stable(ctrl_rdata))
    else $error("control changed without access");
  a_addr_load: assert property ((reg_wr && (reg_addr == cursor_pkg::write_addr_off
    || reg_addr == cursor_pkg::read_addr_off)) ##1 (reg_addr == $past(reg_addr))
    |-> reg_rdata == $past(reg_wdata)) else $error("low address not loaded");
  a_unmapped_zero: assert property (reg_addr != cursor_pkg::write_addr_off && reg_addr !=
    cursor_pkg::read_addr_off && reg_addr != cursor_pkg::ram_data_off |-> reg_rdata == 8'h00)
    else $error("unmapped offset reads nonzero");
  a_full_valid: assert property (!pix_in_ready |-> out_valid)
    else $error("input refused with empty buffer");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_rgb)
    && $stable(out_overlay)) else $error("stalled output word changed");
  a_retrace_clr: assert property ($rose(blank_n) |-> ##[0:2] !retrace)
    else $error("retrace not cleared at blank rise");
  a_retrace_early: assert property ($rose(retrace) |-> cnt_q >= (ctrl_rdata[4] ? 13'h0ff0 : 13'h07f0))
    else $error("retrace raised too early");
  a_retrace_late: assert property (!blank_n && cnt_q == (ctrl_rdata[4] ? 13'h1010 : 13'h0810)
    |-> retrace) else $error("retrace missing after long blank");
endmodule

// ==== pix_sink.sv ====
// pixel sink on the cursor output stream, ready on alternate cycles
`timescale 1ns/1ps
module pix_sink (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [23:0] out_rgb,
  input  wire logic [3:0]  out_overlay,
  output logic             out_ready
);
  logic [27:0] got[$];
  logic        phase_q = 1'b0;
  assign out_ready = !stall && phase_q;
  always @(posedge ref_clk) begin
    phase_q <= reset ? 1'b0 : !phase_q;
    if (!reset && out_valid && out_ready) got.push_back({out_overlay, out_rgb});
  end
endmodule

// ==== hw_cursor_tb.sv ====
// testbench for the hardware cursor block
`timescale 1ns/1ps
module hw_cursor_tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, ind_wdata = 8'h00, ind_index = 8'h00, ctrl_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, ind_wr = 1'b0, blank_n = 1'b0, pix_valid = 1'b0, stall = 1'b0;
  logic [11:0] pos_x = 12'h000, pos_y = 12'h000;
  logic [15:0] pix_in = 16'h0000;
  logic        pix_in_ready, out_valid, out_ready, retrace;
  logic [23:0] out_rgb;
  logic [3:0]  out_overlay;
  int          n_mismatch = 0, total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  hw_cursor uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ind_wr(ind_wr), .ind_index(ind_index), .ind_wdata(ind_wdata),
    .ctrl_rdata(ctrl_rdata), .pos_x(pos_x), .pos_y(pos_y), .blank_n(blank_n), .pix_valid(pix_valid),
    .pix_in(pix_in), .cursor_color0(24'h112233), .cursor_color1(24'h445566), .cursor_color2(24'h778899),
    .pix_in_ready(pix_in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_rgb(out_rgb),
    .out_overlay(out_overlay), .retrace(retrace));
  pix_sink sink (.ref_clk(ref_clk), .reset(reset), .stall(stall), .out_valid(out_valid), .out_rgb(out_rgb),
    .out_overlay(out_overlay), .out_ready(out_ready));
  function automatic logic [23:0] wid(input logic [15:0] p);
    return {p[3:0], p[3:0], p[7:4], p[7:4], p[11:8], p[11:8]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes are raised at a falling edge and dropped one cycle later
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic iw(input logic [7:0] d);
    ind_index = cursor_pkg::ctrl_index;
    ind_wdata = d;
    ind_wr = 1'b1;
    @(negedge ref_clk);
    ind_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    @(negedge ref_clk);
  endtask
  task automatic send(input logic [15:0] p);
    int k;
    pix_in = p;
    pix_valid = 1'b1;
    for (k = 0; k < 50 && pix_in_ready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 50) begin
      n_mismatch++;
      give_verdict();
    end
    @(negedge ref_clk);
  endtask
  // retrace, then one line of four pixels with the sink stalled at first
  task automatic frame(input int n_low, input logic [11:0] x, input logic [11:0] y, input logic [23:0] exp0);
    int base;
    int k;
    base = sink.got.size();
    pos_x = x;
    pos_y = y;
    blank_n = 1'b0;
    repeat (n_low) @(negedge ref_clk);
    chk(retrace, 1'b1);
    blank_n = 1'b1;
    stall = 1'b1;
    send(16'h9a50);
    send(16'h9a51);
    pix_valid = 1'b0;
    #1 chk(pix_in_ready, 1'b0);
    stall = 1'b0;
    send(16'h9a52);
    send(16'h9a53);
    pix_valid = 1'b0;
    for (k = 0; k < 50 && sink.got.size() < base + 4; k++) @(negedge ref_clk);
    if (k == 50) begin
      n_mismatch++;
      give_verdict();
    end
    chk(sink.got[base], {4'h9, exp0});
    chk(sink.got[base+1], {4'h9, wid(16'h9a51)});
    chk(sink.got[base+3], {4'h9, wid(16'h9a53)});
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    blank_n = 1'b1;
    chk(ctrl_rdata, 8'h00);
    rd(4'h5, 8'h00);
    iw(8'h06);
    wr(cursor_pkg::write_addr_off, 8'hfe);
    rd(cursor_pkg::write_addr_off, 8'hfe);
    wr(cursor_pkg::ram_data_off, 8'h5a);
    wr(cursor_pkg::ram_data_off, 8'h01);
    wr(cursor_pkg::ram_data_off, 8'h3c);
    chk(ctrl_rdata, 8'h0a);
    iw(8'h0e);
    wr(cursor_pkg::write_addr_off, 8'hff);
    wr(cursor_pkg::ram_data_off, 8'h01);
    chk(ctrl_rdata, 8'h02);
    iw(8'h06);
    wr(cursor_pkg::read_addr_off, 8'hfe);
    rd(cursor_pkg::ram_data_off, 8'h5a);
    rd(cursor_pkg::ram_data_off, 8'h01);
    rd(cursor_pkg::ram_data_off, 8'h3c);
    rd(cursor_pkg::read_addr_off, 8'h01);
    chk(ctrl_rdata, 8'h0a);
    $display("test ram access done");
    iw(8'h02);
    frame(2100, 12'h001, 12'h001, ~wid(16'h9a50));
    $display("test cursor corner done");
    iw(8'h12);
    frame(4200, 12'h000, 12'h001, wid(16'h9a50));
    $display("test cursor hidden done");
    iw(8'h0b);
    wr(cursor_pkg::write_addr_off, 8'h00);
    wr(cursor_pkg::ram_data_off, 8'h80);
    iw(8'h03);
    wr(cursor_pkg::write_addr_off, 8'h00);
    wr(cursor_pkg::ram_data_off, 8'h00);
    frame(2100, 12'h040, 12'h040, 24'h112233);
    $display("test cursor top-left reference done");
    give_verdict();
  end
endmodule
bind hw_cursor hw_cursor_props props_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ind_wr(ind_wr),
  .ind_index(ind_index), .ind_wdata(ind_wdata), .ctrl_rdata(ctrl_rdata), .blank_n(blank_n),
  .pix_in_ready(pix_in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_rgb(out_rgb),
  .out_overlay(out_overlay), .retrace(retrace));
